// file: keypad_params.svh
// constants for the drive keypad control block
`ifndef KEYPAD_PARAMS_SVH
`define KEYPAD_PARAMS_SVH

// ---------------------------------------------------------------
// clock and key timing
// ---------------------------------------------------------------
`define CLK_PERIOD_NS      5
`define KEY_DEBOUNCE_US    10000
`define KEY_DEBOUNCE_CYC   ((`KEY_DEBOUNCE_US * 1000) / `CLK_PERIOD_NS)

// ---------------------------------------------------------------
// key positions in the press vector
// ---------------------------------------------------------------
`define KEY_COUNT          10
`define K_FUNC             0
`define K_DATA             1
`define K_ENTER            2
`define K_SHIFT            3
`define K_INC              4
`define K_DEC              5
`define K_FWD              6
`define K_REV              7
`define K_STOP             8
`define K_RESET            9

// ---------------------------------------------------------------
// register byte offsets
// ---------------------------------------------------------------
`define OFF_CTRL           8'h00
`define OFF_STATUS         8'h04
`define OFF_EDIT           8'h08
`define OFF_FREQ           8'h0c
`define OFF_DIN            8'h10

// ---------------------------------------------------------------
// field reset values and codes
// ---------------------------------------------------------------
`define SRC_PANEL_KEYS     2'h0
`define SRC_PANEL_POT      2'h1
`define RST_FREQ_SRC       2'h1
`define RST_DISP_SEL       5'h01
`define DISP_SEL_DIN       5'h0b
`define DISP_SEL_CODE      8'h04
`define MON_LAST           3'h4

`endif

// file: keypad_pkg.sv
// types shared by the drive keypad control block
package keypad_pkg;

	// panel operating modes
	typedef enum logic [1:0] {
		MODE_CTRL,
		MODE_CODE,
		MODE_LOAD,
		MODE_EDIT
	} panel_mode_t;

	// rotation direction restriction
	typedef enum logic [1:0] {
		DIR_ANY,
		DIR_FWD_ONLY,
		DIR_REV_ONLY,
		DIR_RSVD
	} dir_limit_t;

endpackage

// file: key_debounce.sv
// key synchroniser, debouncer and press detector
`timescale 1ns/1ps
module key_debounce #(
	parameter int N_KEYS  = 10,
	parameter int DEB_CYC = 2000000
) (
	// clock and reset
	input  wire logic              pclk,
	input  wire logic              presetn,
	// raw keys, high while pressed
	input  wire logic [N_KEYS-1:0] keys_raw,
	// one-cycle press pulses
	output logic      [N_KEYS-1:0] press_ff
);
	localparam int CW = $clog2(DEB_CYC + 1);

	genvar i;
	generate
		for (i = 0; i < N_KEYS; i++) begin : g_key
			logic          s1_ff, s2_ff, s3_ff, level_ff;
			logic [CW-1:0] cnt_ff;
			wire           agree  = (s2_ff == s3_ff);
			wire           differ = agree && (s3_ff != level_ff);
			wire           settle = differ && (cnt_ff == CW'(DEB_CYC - 1));
			// three-stage sync; only the third stage is compared with the second
			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					s1_ff    <= 1'b0;
					s2_ff    <= 1'b0;
					s3_ff    <= 1'b0;
					level_ff <= 1'b0;
					cnt_ff   <= '0;
					press_ff[i] <= 1'b0;
				end else begin
					s1_ff <= keys_raw[i];
					s2_ff <= s1_ff;
					s3_ff <= s2_ff;
					// any bounce restarts the settle count
					cnt_ff <= (differ && !settle) ? cnt_ff + CW'(1) : '0;
					if (settle) begin
						level_ff <= s3_ff;
					end
					press_ff[i] <= settle && s3_ff;
				end
			end
		end
	endgenerate

endmodule // key_debounce

// file: din_weigh.sv
// digital input synchroniser and weighted status value
`timescale 1ns/1ps
module din_weigh (
	// clock and reset
	input  wire logic       pclk,
	input  wire logic       presetn,
	// multifunction input levels, input_one in bit 0
	input  wire logic [7:0] din_raw,
	// weighted status value
	output logic      [7:0] din_value_ff
);
	logic [7:0] lvl;

	genvar i;
	generate
		for (i = 0; i < 8; i++) begin : g_bit
			logic s1_ff, s2_ff, s3_ff, lvl_ff;
			// three-stage sync, level moves when stages two and three agree
			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					s1_ff  <= 1'b0;
					s2_ff  <= 1'b0;
					s3_ff  <= 1'b0;
					lvl_ff <= 1'b0;
				end else begin
					s1_ff <= din_raw[i];
					s2_ff <= s1_ff;
					s3_ff <= s2_ff;
					if (s2_ff == s3_ff) begin
						lvl_ff <= s3_ff;
					end
				end
			end
			assign lvl[i] = lvl_ff;
		end
	endgenerate

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			din_value_ff <= 8'h00;
		end else begin
			din_value_ff <= {7'h00, lvl[0]} + {6'h00, lvl[1], 1'b0} + {5'h00, lvl[2], 2'h0}
				+ {4'h0, lvl[3], 3'h0} + {3'h0, lvl[4], 4'h0} + {2'h0, lvl[5], 5'h00}
				+ {1'b0, lvl[6], 6'h00} + {lvl[7], 7'h00};
		end
	end

endmodule // din_weigh

// file: drive_keypad_control.sv
// drive front panel key handling, command issue and display selection
//
// Functional notes
// - function key enters parameter mode
// - data key reads then edits parameter value
// - enter commits value to nonvolatile memory
// - shift moves edit cursor one digit right
// - shift cycles monitored quantity while running
// - increment raises digit under edit
// - increment adjusts frequency when source is panel
// - decrement lowers digit under edit
// - decrement opens display selection in control
// - forward key runs forward, lights lamp
// - forward key stops unless forward-only
// - reverse key runs reverse, lights lamp
// - reverse key stops unless reverse-only
// - stop key issues stop command
// - reset clears fault or restores value
// - source one takes speed from potentiometer
// - panel speed keys ignored unless source zero
// - enter or data saves and exits edit
// - input status is weighted input sum
// - input status shown at select 11, running
//
// Decided for this implementation: the APB register port and the placing of the registers.
`timescale 1ns/1ps
`include "keypad_params.svh"
module drive_keypad_control #(
	parameter int DEB_CYC   = `KEY_DEBOUNCE_CYC,
	parameter int FREQ_MAX  = 9999,
	parameter int FREQ_STEP = 1
) (
	// clock and reset
	input  wire logic        pclk,
	input  wire logic        presetn,
	// apb slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// panel keys, high while pressed
	input  wire logic        param_mode_key,
	input  wire logic        data_key,
	input  wire logic        enter_key,
	input  wire logic        shift_key,
	input  wire logic        inc_key,
	input  wire logic        dec_key,
	input  wire logic        forward_run_key,
	input  wire logic        reverse_run_key,
	input  wire logic        stop_key,
	input  wire logic        reset_key,
	// multifunction inputs
	input  wire logic        input_one,
	input  wire logic        input_two,
	input  wire logic        input_three,
	input  wire logic        input_four,
	input  wire logic        input_five,
	input  wire logic        input_six,
	input  wire logic        input_seven,
	input  wire logic        input_eight,
	// drive core status
	input  wire logic        fault_active,
	input  wire logic [11:0] panel_pot_input,
	input  wire logic [15:0] param_rdata,
	// drive core commands
	output logic             run_fwd_cmd,
	output logic             run_rev_cmd,
	output logic             stop_cmd,
	output logic             fault_clr,
	output logic             param_rd,
	output logic             param_wr,
	output logic             nv_commit,
	output logic      [7:0]  param_code,
	output logic      [15:0] param_wdata,
	output logic      [15:0] speed_ref,
	// indication and display
	output logic             fwd_lamp,
	output logic             rev_lamp,
	output logic      [2:0]  monitor_sel,
	output logic      [7:0]  din_value,
	output logic             din_show
);
	import keypad_pkg::*;

	// ---------------------------------------------------------------
	// state
	// ---------------------------------------------------------------
	panel_mode_t      mode_ff, nxt_mode;
	dir_limit_t       dir_ff;
	logic [1:0]       src_ff;
	logic [4:0]       disp_ff;
	logic [7:0]       code_ff, nxt_code;
	logic [15:0]      edit_ff, nxt_edit, orig_ff, nxt_orig, freq_ff, nxt_freq;
	logic [1:0]       cursor_ff, nxt_cursor;
	logic [2:0]       mon_ff, nxt_mon;
	logic             run_ff, nxt_run, fwd_ff, nxt_fwd;
	logic             nxt_run_fwd, nxt_run_rev, nxt_stop, nxt_fclr, nxt_rd, nxt_wr;
	logic             pready_ff, pslverr_ff, din_show_ff;
	logic [31:0]      prdata_ff;
	logic [`KEY_COUNT-1:0] press;

	// ---------------------------------------------------------------
	// key and input front ends
	// ---------------------------------------------------------------
	key_debounce #(.N_KEYS(`KEY_COUNT), .DEB_CYC(DEB_CYC)) u_keys (
		.pclk     (pclk),
		.presetn  (presetn),
		.keys_raw ({reset_key, stop_key, reverse_run_key, forward_run_key, dec_key,
		            inc_key, shift_key, enter_key, data_key, param_mode_key}),
		.press_ff (press)
	);

	din_weigh u_din (
		.pclk         (pclk),
		.presetn      (presetn),
		.din_raw      ({input_eight, input_seven, input_six, input_five,
		                input_four, input_three, input_two, input_one}),
		.din_value_ff (din_value)
	);

	// ---------------------------------------------------------------
	// digit helpers
	// ---------------------------------------------------------------
	// step one bcd digit, wrapping 9 to 0 and back
	function automatic logic [15:0] bcd_step(input logic [15:0] v, input logic [1:0] nib,
	                                         input logic up);
		logic [3:0]  d;
		logic [15:0] r;
		r = v;
		d = v[nib*4 +: 4];
		if (up) begin
			d = (d >= 4'h9) ? 4'h0 : d + 4'h1;
		end else begin
			d = (d == 4'h0) ? 4'h9 : d - 4'h1;
		end
		r[nib*4 +: 4] = d;
		return r;
	endfunction

	// cursor 0 is the leftmost digit; code has two digits, value four
	wire [1:0]  code_nib  = 2'h1 - cursor_ff;
	wire [1:0]  edit_nib  = 2'h3 - cursor_ff;
	wire [15:0] code_up   = bcd_step({8'h00, code_ff}, code_nib, 1'b1);
	wire [15:0] code_dn   = bcd_step({8'h00, code_ff}, code_nib, 1'b0);
	wire [2:0]  mon_next  = (mon_ff == `MON_LAST) ? 3'h0 : mon_ff + 3'h1;
	wire [15:0] freq_up   = (freq_ff > 16'(FREQ_MAX - FREQ_STEP)) ? 16'(FREQ_MAX)
	                        : freq_ff + 16'(FREQ_STEP);
	wire        panel_src = (src_ff == `SRC_PANEL_KEYS);

	// ---------------------------------------------------------------
	// key interpreter
	// ---------------------------------------------------------------
	always_comb begin
		nxt_mode    = mode_ff;
		nxt_code    = code_ff;
		nxt_edit    = edit_ff;
		nxt_orig    = orig_ff;
		nxt_cursor  = cursor_ff;
		nxt_mon     = mon_ff;
		nxt_freq    = freq_ff;
		nxt_run     = run_ff;
		nxt_fwd     = fwd_ff;
		nxt_run_fwd = 1'b0;
		nxt_run_rev = 1'b0;
		nxt_stop    = 1'b0;
		nxt_fclr    = 1'b0;
		nxt_rd      = 1'b0;
		nxt_wr      = 1'b0;
		// run keys work in every mode; a pending fault refuses a start
		if (press[`K_FWD]) begin
			if (run_ff && fwd_ff && dir_ff != DIR_FWD_ONLY) begin
				nxt_stop = 1'b1;
				nxt_run  = 1'b0;
			end else if (!fault_active && dir_ff != DIR_REV_ONLY) begin
				nxt_run_fwd = 1'b1;
				nxt_run     = 1'b1;
				nxt_fwd     = 1'b1;
			end
		end else if (press[`K_REV]) begin
			if (run_ff && !fwd_ff && dir_ff != DIR_REV_ONLY) begin
				nxt_stop = 1'b1;
				nxt_run  = 1'b0;
			end else if (!fault_active && dir_ff != DIR_FWD_ONLY) begin
				nxt_run_rev = 1'b1;
				nxt_run     = 1'b1;
				nxt_fwd     = 1'b0;
			end
		end else if (press[`K_STOP]) begin
			nxt_stop = 1'b1;
			nxt_run  = 1'b0;
		end
		if (press[`K_RESET] && fault_active) begin
			nxt_fclr = 1'b1;
		end
		unique case (mode_ff)
			MODE_CTRL: begin
				if (press[`K_FUNC]) begin
					nxt_mode   = MODE_CODE;
					nxt_cursor = 2'h0;
				end else if (press[`K_DEC]) begin
					nxt_mode   = MODE_CODE;
					nxt_code   = `DISP_SEL_CODE;
					nxt_cursor = 2'h0;
				end else if (press[`K_SHIFT] && run_ff) begin
					nxt_mon = mon_next;
				// panel frequency only from source zero
				end else if (press[`K_INC] && panel_src) begin
					nxt_freq = freq_up;
				end
			end
			MODE_CODE: begin
				if (press[`K_FUNC]) begin
					nxt_mode = MODE_CTRL;
				end else if (press[`K_DATA]) begin
					nxt_mode = MODE_LOAD;
					nxt_rd   = 1'b1;
				// cursor right over two code digits
				end else if (press[`K_SHIFT]) begin
					nxt_cursor = (cursor_ff == 2'h1) ? 2'h0 : cursor_ff + 2'h1;
				end else if (press[`K_INC]) begin
					nxt_code = code_up[7:0];
				end else if (press[`K_DEC]) begin
					nxt_code = code_dn[7:0];
				end
			end
			MODE_LOAD: begin
				// take the stored value, keep a copy for reset
				nxt_edit   = param_rdata;
				nxt_orig   = param_rdata;
				nxt_cursor = 2'h0;
				nxt_mode   = MODE_EDIT;
			end
			MODE_EDIT: begin
				if (press[`K_FUNC]) begin
					nxt_mode = MODE_CODE;
				end else if (press[`K_RESET] && !fault_active) begin
					nxt_edit = orig_ff;
				end else if (press[`K_ENTER] || press[`K_DATA]) begin
					nxt_wr   = 1'b1;
					nxt_orig = edit_ff;
					nxt_mode = MODE_CTRL;
				// cursor right over four value digits
				end else if (press[`K_SHIFT]) begin
					nxt_cursor = cursor_ff + 2'h1;
				end else if (press[`K_INC]) begin
					nxt_edit = bcd_step(edit_ff, edit_nib, 1'b1);
				end else if (press[`K_DEC]) begin
					nxt_edit = bcd_step(edit_ff, edit_nib, 1'b0);
				end
			end
		endcase
	end

	// panel state registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mode_ff     <= MODE_CTRL;
			code_ff     <= 8'h00;
			edit_ff     <= 16'h0000;
			orig_ff     <= 16'h0000;
			cursor_ff   <= 2'h0;
			mon_ff      <= 3'h0;
			freq_ff     <= 16'h0000;
			run_ff      <= 1'b0;
			fwd_ff      <= 1'b1;
		end else begin
			mode_ff     <= nxt_mode;
			code_ff     <= nxt_code;
			edit_ff     <= nxt_edit;
			orig_ff     <= nxt_orig;
			cursor_ff   <= nxt_cursor;
			mon_ff      <= nxt_mon;
			freq_ff     <= nxt_freq;
			run_ff      <= nxt_run;
			fwd_ff      <= nxt_fwd;
		end
	end

	// outputs to the drive core, all registered
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			{run_fwd_cmd, run_rev_cmd, stop_cmd, fault_clr} <= 4'h0;
			{param_rd, param_wr, nv_commit, fwd_lamp, rev_lamp} <= 5'h00;
			param_code  <= 8'h00;
			param_wdata <= 16'h0000;
			speed_ref   <= 16'h0000;
			monitor_sel <= 3'h0;
			din_show_ff <= 1'b0;
		end else begin
			{run_fwd_cmd, run_rev_cmd, stop_cmd, fault_clr} <=
				{nxt_run_fwd, nxt_run_rev, nxt_stop, nxt_fclr};
			param_rd    <= nxt_rd;
			param_wr    <= nxt_wr;
			// commit pulse rides with the write, no extra key needed
			nv_commit   <= nxt_wr;
			fwd_lamp    <= nxt_run && nxt_fwd;
			rev_lamp    <= nxt_run && !nxt_fwd;
			param_code  <= nxt_code;
			param_wdata <= nxt_edit;
			// pot or panel keys as speed reference
			speed_ref   <= (src_ff == `SRC_PANEL_POT) ? {4'h0, panel_pot_input} : freq_ff;
			monitor_sel <= nxt_mon;
			din_show_ff <= nxt_run && (disp_ff == `DISP_SEL_DIN);
		end
	end
	assign din_show = din_show_ff;

	// ---------------------------------------------------------------
	// apb slave
	// ---------------------------------------------------------------
	wire setup    = psel && !penable;
	wire wr_acc   = psel && penable && pwrite && pready_ff;
	wire hit_ctrl = (paddr == `OFF_CTRL);
	wire mapped   = hit_ctrl || (paddr == `OFF_STATUS) || (paddr == `OFF_EDIT)
	                || (paddr == `OFF_FREQ) || (paddr == `OFF_DIN);
	wire [31:0] rd_word =
		hit_ctrl                 ? {23'h0, dir_ff, disp_ff, src_ff} :
		(paddr == `OFF_STATUS)   ? {21'h0, mon_ff, cursor_ff, fault_active, rev_lamp,
		                            fwd_lamp, run_ff, mode_ff} :
		(paddr == `OFF_EDIT)     ? {8'h0, edit_ff, code_ff} :
		(paddr == `OFF_FREQ)     ? {16'h0, freq_ff} :
		(paddr == `OFF_DIN)      ? {23'h0, din_show_ff, din_value} : 32'h0;

	// answer is prepared in setup so the access phase never waits
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_ff  <= 1'b0;
			pslverr_ff <= 1'b0;
			prdata_ff  <= 32'h0;
			src_ff     <= `RST_FREQ_SRC;
			disp_ff    <= `RST_DISP_SEL;
			dir_ff     <= DIR_ANY;
		end else begin
			pready_ff  <= setup;
			pslverr_ff <= setup && !mapped;
			prdata_ff  <= (setup && !pwrite) ? rd_word : 32'h0;
			if (wr_acc && hit_ctrl) begin
				src_ff  <= pwdata[1:0];
				disp_ff <= pwdata[6:2];
				dir_ff  <= dir_limit_t'(pwdata[8:7]);
			end
		end
	end
	assign pready  = pready_ff;
	assign pslverr = pslverr_ff;
	assign prdata  = prdata_ff;

	// ---------------------------------------------------------------
	// checks
	// ---------------------------------------------------------------
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	sequence s_commit;
		param_wr && nv_commit && mode_ff == MODE_CTRL;
	endsequence
	sequence s_load;
		param_rd ##1 (mode_ff == MODE_EDIT && edit_ff == $past(param_rdata));
	endsequence

	a_fwd_start_lamp: assert property (
		press[`K_FWD] && !run_ff && !fault_active && dir_ff == DIR_ANY
		|=> run_fwd_cmd && fwd_lamp && !rev_lamp) else $error("forward start missing");
	a_fwd_as_stop: assert property (
		press[`K_FWD] && run_ff && fwd_ff && dir_ff != DIR_FWD_ONLY
		|=> stop_cmd && !fwd_lamp) else $error("forward key did not stop");
	a_stop_key_cmd: assert property (
		press[`K_STOP] && !press[`K_FWD] && !press[`K_REV]
		|=> stop_cmd && !fwd_lamp && !rev_lamp) else $error("stop key ignored");
	a_data_read_load: assert property (
		mode_ff == MODE_CODE && press[`K_DATA] && !press[`K_FUNC] |=> s_load)
		else $error("parameter value not loaded");
	a_enter_commit: assert property (
		mode_ff == MODE_EDIT && press[`K_ENTER] && !press[`K_FUNC] && !press[`K_RESET]
		|=> s_commit) else $error("enter did not commit and exit");
	a_monitor_cycle: assert property (
		mode_ff == MODE_CTRL && run_ff && press[`K_SHIFT] && !press[`K_FUNC]
		&& !press[`K_DEC] |=> mon_ff == (($past(mon_ff) == 3'h4) ? 3'h0 : $past(mon_ff) + 3'h1))
		else $error("monitor did not advance");
	a_freq_src_ignore: assert property (
		!panel_src |=> $stable(freq_ff)) else $error("panel frequency moved off source zero");
	a_pot_speed_ref: assert property (
		src_ff == `SRC_PANEL_POT |=> speed_ref == {4'h0, $past(panel_pot_input)})
		else $error("speed reference not from potentiometer");
	a_reset_restore: assert property (
		mode_ff == MODE_EDIT && press[`K_RESET] && !fault_active && !press[`K_FUNC]
		|=> edit_ff == $past(orig_ff)) else $error("reset did not restore value");
	a_din_idle_hide: assert property (
		!run_ff && !press[`K_FWD] && !press[`K_REV] |=> !din_show)
		else $error("input status shown while stopped");

endmodule // drive_keypad_control

// file: key_operator.sv
// operator model that presses one panel key at a time
`timescale 1ns/1ps
module key_operator #(
	parameter int HOLD = 40,
	parameter int GAP  = 40
) (
	// clock
	input  wire logic       pclk,
	// raw key levels, high while pressed
	output logic      [9:0] keys
);
	initial keys = '0;

	// the hold runs far past the debounce time, so a long press
	// must still yield one action; the gap lets the release settle
	task automatic press(input int k);
		@(posedge pclk);
		keys[k] <= 1'b1;
		repeat (HOLD) @(posedge pclk);
		keys[k] <= 1'b0;
		repeat (GAP) @(posedge pclk);
	endtask
endmodule // key_operator

// file: test_drive_keypad_control.sv
// self-checking bench for the drive keypad control block
`timescale 1ns/1ps
`include "keypad_params.svh"
module test_drive_keypad_control;
	// ----
	// signals
	// ----
	localparam int C_FWD = 0, C_REV = 1, C_STOP = 2, C_CLR = 3, C_RD = 4, C_WR = 5, C_NV = 6;
	logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, fault_active = 0;
	logic [7:0]  paddr = '0, din = '0, din_value, param_code;
	logic [11:0] pot = 12'habc;
	logic [31:0] pwdata = '0, prdata, rd;
	logic        pready, pslverr, er, fwd_lamp, rev_lamp, din_show;
	logic        run_fwd_cmd, run_rev_cmd, stop_cmd, fault_clr, param_rd, param_wr, nv_commit;
	logic [15:0] param_wdata, speed_ref, last_wd;
	logic [2:0]  monitor_sel;
	logic [9:0]  keys;
	logic [6:0]  pulses;
	int          cnt[7], base[7];
	int          failures = 0, compares = 0;

	always #2.5 pclk = ~pclk;
	assign pulses = {nv_commit, param_wr, param_rd, fault_clr, stop_cmd, run_rev_cmd, run_fwd_cmd};

	key_operator op (.pclk(pclk), .keys(keys));

	// short debounce keeps each press under a hundred cycles
	drive_keypad_control #(.DEB_CYC(4)) uut (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.param_mode_key(keys[`K_FUNC]), .data_key(keys[`K_DATA]), .enter_key(keys[`K_ENTER]),
		.shift_key(keys[`K_SHIFT]), .inc_key(keys[`K_INC]), .dec_key(keys[`K_DEC]),
		.forward_run_key(keys[`K_FWD]), .reverse_run_key(keys[`K_REV]),
		.stop_key(keys[`K_STOP]), .reset_key(keys[`K_RESET]),
		.input_one(din[0]), .input_two(din[1]), .input_three(din[2]), .input_four(din[3]),
		.input_five(din[4]), .input_six(din[5]), .input_seven(din[6]), .input_eight(din[7]),
		.fault_active(fault_active), .panel_pot_input(pot), .param_rdata(16'h1234),
		.run_fwd_cmd(run_fwd_cmd), .run_rev_cmd(run_rev_cmd), .stop_cmd(stop_cmd),
		.fault_clr(fault_clr), .param_rd(param_rd), .param_wr(param_wr),
		.nv_commit(nv_commit), .param_code(param_code), .param_wdata(param_wdata),
		.speed_ref(speed_ref), .fwd_lamp(fwd_lamp), .rev_lamp(rev_lamp),
		.monitor_sel(monitor_sel), .din_value(din_value), .din_show(din_show));

	// pulse tally and last committed value; scenarios judge deltas
	always @(posedge pclk) begin
		for (int i = 0; i < 7; i++)
			if (pulses[i] === 1'b1) cnt[i] <= cnt[i] + 1;
		if (param_wr === 1'b1) last_wd <= param_wdata;
	end

	// ----
	// shared tasks
	// ----
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			failures++;
			$display("MISMATCH at %0t got %h exp %h", $time, got, exp);
		end
	endtask

	task automatic chkd(input int i, input int n);
		chk(cnt[i] - base[i], n);
	endtask

	task automatic key(input int k);
		base = cnt;
		op.press(k);
	endtask

	// request held until pready is seen high at an edge
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		chk({31'h0, pready}, 32'h1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		repeat (2) @(posedge pclk);
	endtask

	task automatic close_out;
		$display("compares %0d failures %0d", compares, failures);
		if (failures == 0 && compares > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	// ----
	// scenarios
	// ----
	task automatic t_regs_din;
		logic [7:0] tbl[4] = '{8'h2a, 8'h57, 8'hff, 8'h00};
		apb(1'b0, `OFF_CTRL, 32'h0);
		chk(rd, 32'h5);
		apb(1'b0, 8'h20, 32'h0);
		chk({31'h0, er}, 32'h1);
		foreach (tbl[i]) begin
			din <= tbl[i];
			repeat (8) @(posedge pclk);
			chk(din_value, tbl[i]);
		end
	endtask

	task automatic t_run;
		key(`K_FWD);
		chkd(C_FWD, 1);
		chk(fwd_lamp, 1);
		for (int i = 1; i <= 5; i++) begin
			key(`K_SHIFT);
			chk(monitor_sel, i % 5);
		end
		apb(1'b1, `OFF_CTRL, 32'h2d);
		chk(din_show, 1);
		chk(speed_ref, 16'h0abc);
		// the reference must follow the pot, not hold a stale sample
		pot <= 12'h5e1;
		repeat (3) @(posedge pclk);
		chk(speed_ref, 16'h05e1);
		// speed_ref shows the pot here, so judge the panel frequency itself
		key(`K_INC);
		apb(1'b0, `OFF_FREQ, 32'h0);
		chk(rd, 32'h0);
		key(`K_FWD);
		chkd(C_STOP, 1);
		chk({fwd_lamp, din_show}, 0);
		key(`K_REV);
		chkd(C_REV, 1);
		chk(rev_lamp, 1);
		key(`K_STOP);
		chkd(C_STOP, 1);
		chk(rev_lamp, 0);
	endtask

	task automatic t_speed_fault;
		logic [15:0] s;
		apb(1'b1, `OFF_CTRL, 32'h2c);
		s = speed_ref;
		key(`K_INC);
		chk(speed_ref, s + 16'h1);
		fault_active <= 1'b1;
		key(`K_FWD);
		chkd(C_FWD, 0);
		key(`K_RESET);
		chkd(C_CLR, 1);
		fault_active <= 1'b0;
	endtask

	// reverse as stop, direction limit and the display-select shortcut
	task automatic t_dir_disp;
		key(`K_REV);
		key(`K_REV);
		chkd(C_STOP, 1);
		apb(1'b1, `OFF_CTRL, 32'hac);
		key(`K_REV);
		chkd(C_REV, 0);
		key(`K_DEC);
		chk(param_code, `DISP_SEL_CODE);
	endtask

	task automatic edit(input int a, input int b, input logic [15:0] exp);
		key(`K_FUNC);
		key(`K_DATA);
		chkd(C_RD, 1);
		key(a);
		if (b >= 0) key(b);
		key(`K_ENTER);
		chkd(C_WR, 1);
		chkd(C_NV, 1);
		chk(last_wd, exp);
	endtask

	// main sequence, reset held for eight cycles
	initial begin
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		repeat (40) @(posedge pclk);
		t_regs_din;
		t_run;
		t_speed_fault;
		edit(`K_INC, -1, 16'h2234);
		edit(`K_DEC, -1, 16'h0234);
		edit(`K_SHIFT, `K_INC, 16'h1334);
		edit(`K_INC, `K_RESET, 16'h1234);
		t_dir_disp;
		close_out;
	end

	// watchdog well beyond the expected run of about 3000 cycles
	initial begin
		repeat (10000) @(posedge pclk);
		failures++;
		close_out;
	end
endmodule // test_drive_keypad_control
